// *** shared/art_defs.vh ***
// register map, field positions, reset values and counts for the auto-reload timer
`ifndef ART_DEFS_VH
`define ART_DEFS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define ART_OFS_CTRL      8'h00
`define ART_OFS_CNT_LO    8'h04
`define ART_OFS_CNT_HI    8'h08
`define ART_OFS_RL_LO     8'h0C
`define ART_OFS_RL_HI     8'h10
`define ART_OFS_CKCTRL    8'h14
`define ART_OFS_INT_EN    8'h18
`define ART_OFS_IRQ_STAT  8'h1C
`define ART_OFS_IRQ_MASK  8'h20

// ************************************************************
// field positions
// ************************************************************
`define ART_CTRL_HOF      7
`define ART_CTRL_LOF      6
`define ART_CTRL_LBIE     5
`define ART_CTRL_CAP      4
`define ART_CTRL_SPLIT    3
`define ART_CTRL_RUN      2
`define ART_CKC_LOW       0
`define ART_CKC_HIGH      1
`define ART_IRQ_HIGH      0
`define ART_IRQ_LOW       1

// ************************************************************
// reset values and encodings
// ************************************************************
`define ART_CTRL_RST      8'h00
`define ART_CKC_RST       2'h0
`define ART_MASK_RST      2'h3
`define ART_XSEL_DIV12    2'h0
`define ART_XSEL_RTC      2'h1
`define ART_XSEL_RSVD     2'h2
`define ART_XSEL_EXT8     2'h3
`define ART_RESP_OKAY     2'h0
`define ART_RESP_SLVERR   2'h2

// ************************************************************
// timing counts
// ************************************************************
`define ART_DIV12_LAST    4'hB
`define ART_EXT8_LAST     3'h7

`endif

// *** rtl/art_sync.v ***
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none

module art_sync (
  input  wire mclk,
  input  wire rst,
  input  wire din,
  output reg  level,
  output reg  rise
);

  reg q1;
  reg q2;
  reg q3;

  // q1 feeds q2 only; a change counts once q2 and q3 agree
  always @(posedge mclk) begin
    if (rst) begin
      q1    <= 1'b0;
      q2    <= 1'b0;
      q3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      q1    <= din;
      q2    <= q1;
      q3    <= q2;
      if (q2 == q3) begin
        level <= q3;
      end
      rise  <= (q2 == q3) & q3 & ~level;
    end
  end

endmodule // art_sync

`default_nettype wire

// *** rtl/art_timer.v ***
// auto-reload 16/8-bit timer with oscillator capture, AXI4-Lite register slave
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "art_defs.vh"

module art_timer (
  input  wire        mclk,
  input  wire        rst,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // oscillator inputs from pins
  input  wire        rtc_clk_pin,
  input  wire        ext_osc_pin,
  // interrupt request
  output wire        irq
);

  // ************************************************************
  // registers
  // ************************************************************
  reg  [7:0]  timer_control_reg;
  reg  [15:0] count;
  reg  [15:0] reload;
  reg  [1:0]  clock_control_reg;
  reg         extended_interrupt_enable_reg;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;

  wire        high_overflow_flag        = timer_control_reg[`ART_CTRL_HOF];
  wire        low_overflow_flag         = timer_control_reg[`ART_CTRL_LOF];
  wire        low_byte_interrupt_enable = timer_control_reg[`ART_CTRL_LBIE];
  wire        capture_enable            = timer_control_reg[`ART_CTRL_CAP];
  wire        split_select              = timer_control_reg[`ART_CTRL_SPLIT];
  wire        run_control               = timer_control_reg[`ART_CTRL_RUN];
  wire [1:0]  external_select           = timer_control_reg[1:0];
  wire        low_byte_clock_select     = clock_control_reg[`ART_CKC_LOW];
  wire        high_byte_clock_select    = clock_control_reg[`ART_CKC_HIGH];

  // ************************************************************
  // axi write channel
  // ************************************************************
  reg         aw_held;
  reg  [7:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        do_write;
  wire        wr_lane0;
  reg         wr_mapped;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  // the write lands one cycle after both halves are held
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign wr_lane0      = do_write & w_strb[0];

  // address and data are latched independently, in either order
  always @(posedge mclk) begin
    if (rst) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ART_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write address decode, one strobe per register
  reg wr_ctrl;
  reg wr_cnt_lo;
  reg wr_cnt_hi;
  reg wr_rl_lo;
  reg wr_rl_hi;
  reg wr_ckc;
  reg wr_ien;
  reg wr_stat;
  reg wr_mask;

  always @* begin
    wr_ctrl   = 1'b0;
    wr_cnt_lo = 1'b0;
    wr_cnt_hi = 1'b0;
    wr_rl_lo  = 1'b0;
    wr_rl_hi  = 1'b0;
    wr_ckc    = 1'b0;
    wr_ien    = 1'b0;
    wr_stat   = 1'b0;
    wr_mask   = 1'b0;
    wr_mapped = 1'b1;
    case ({aw_addr[7:2], 2'b00})
      `ART_OFS_CTRL:     wr_ctrl   = wr_lane0;
      `ART_OFS_CNT_LO:   wr_cnt_lo = wr_lane0;
      `ART_OFS_CNT_HI:   wr_cnt_hi = wr_lane0;
      `ART_OFS_RL_LO:    wr_rl_lo  = wr_lane0;
      `ART_OFS_RL_HI:    wr_rl_hi  = wr_lane0;
      `ART_OFS_CKCTRL:   wr_ckc    = wr_lane0;
      `ART_OFS_INT_EN:   wr_ien    = wr_lane0;
      `ART_OFS_IRQ_STAT: wr_stat   = wr_lane0;
      `ART_OFS_IRQ_MASK: wr_mask   = wr_lane0;
      default:           wr_mapped = 1'b0;
    endcase
  end

  // ************************************************************
  // clock sources
  // ************************************************************
  wire rtc_level;
  wire rtc_rise;
  wire ext_level;
  wire ext_rise;

  // asynchronous oscillators only reach the counter through these
  art_sync u_rtc_sync (
    .mclk  (mclk),
    .rst   (rst),
    .din   (rtc_clk_pin),
    .level (rtc_level),
    .rise  (rtc_rise)
  );

  art_sync u_ext_sync (
    .mclk  (mclk),
    .rst   (rst),
    .din   (ext_osc_pin),
    .level (ext_level),
    .rise  (ext_rise)
  );

  reg  [3:0] div12_cnt;
  reg  [2:0] ext8_cnt;
  wire       div12_tick = (div12_cnt == `ART_DIV12_LAST);
  wire       ext8_tick  = ext_rise & (ext8_cnt == `ART_EXT8_LAST);

  // free-running prescalers: /12 of mclk, /8 of synchronised ext edges
  always @(posedge mclk) begin
    if (rst) begin
      div12_cnt <= 4'h0;
      ext8_cnt  <= 3'h0;
    end else begin
      div12_cnt <= div12_tick ? 4'h0 : div12_cnt + 4'h1;
      if (ext_rise) begin
        ext8_cnt <= ext8_cnt + 3'h1;
      end
    end
  end

  // shared "external" tick picked by the two-bit select
  reg ext_tick;
  always @* begin
    case (external_select)
      `ART_XSEL_DIV12: ext_tick = div12_tick;
      `ART_XSEL_RTC:   ext_tick = rtc_rise;
      `ART_XSEL_EXT8:  ext_tick = ext8_tick;
      default:         ext_tick = 1'b0;
    endcase
  end

  // per-byte choice of system clock or the external tick
  wire [1:0] byte_sel = {high_byte_clock_select, low_byte_clock_select};
  wire [1:0] byte_tick;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_byte_clk
      assign byte_tick[gi] = byte_sel[gi] ? 1'b1 : ext_tick;
    end
  endgenerate

  // capture trigger: rtc edge, or every eighth ext clock
  wire cap_trig = external_select[1] ? ext8_tick : rtc_rise;
  wire cap_evt  = capture_enable & cap_trig;

  // ************************************************************
  // counting
  // ************************************************************
  reg [15:0] next_count;
  reg [15:0] next_reload;
  reg        hi_wrap;
  reg        lo_wrap;

  always @* begin
    next_count  = count;
    next_reload = reload;
    hi_wrap     = 1'b0;
    lo_wrap     = 1'b0;
    if (!split_select) begin
      // full counter, clocked by the low-byte source
      if (run_control && byte_tick[0]) begin
        lo_wrap = (count[7:0] == 8'hFF);
        if (count == 16'hFFFF) begin
          hi_wrap    = 1'b1;
          // capture keeps counting so differences stay meaningful
          next_count = capture_enable ? 16'h0000 : reload;
        end else begin
          next_count = count + 16'h0001;
        end
      end
    end else begin
      // low byte ignores run control in split mode
      if (byte_tick[0]) begin
        if (count[7:0] == 8'hFF) begin
          lo_wrap          = 1'b1;
          next_count[7:0]  = reload[7:0];
        end else begin
          next_count[7:0]  = count[7:0] + 8'h01;
        end
      end
      if (run_control && byte_tick[1]) begin
        if (count[15:8] == 8'hFF) begin
          hi_wrap          = 1'b1;
          next_count[15:8] = reload[15:8];
        end else begin
          next_count[15:8] = count[15:8] + 8'h01;
        end
      end
    end
    if (cap_evt) begin
      next_reload = count;
    end
  end

  wire hi_set = hi_wrap | cap_evt;

  // software writes to count or reload take priority over hardware
  always @(posedge mclk) begin
    if (rst) begin
      count  <= 16'h0000;
      reload <= 16'h0000;
    end else begin
      count[7:0]   <= wr_cnt_lo ? w_data[7:0] : next_count[7:0];
      count[15:8]  <= wr_cnt_hi ? w_data[7:0] : next_count[15:8];
      reload[7:0]  <= wr_rl_lo  ? w_data[7:0] : next_reload[7:0];
      reload[15:8] <= wr_rl_hi  ? w_data[7:0] : next_reload[15:8];
    end
  end

  // ************************************************************
  // control and flags
  // ************************************************************
  // flags set by hardware or by a control write of one; a same-cycle zero write loses
  always @(posedge mclk) begin
    if (rst) begin
      timer_control_reg             <= `ART_CTRL_RST;
      clock_control_reg             <= `ART_CKC_RST;
      extended_interrupt_enable_reg <= 1'b0;
      irq_mask                      <= `ART_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        timer_control_reg <= w_data[7:0];
      end
      if (hi_set) begin
        timer_control_reg[`ART_CTRL_HOF] <= 1'b1;
      end
      if (lo_wrap) begin
        timer_control_reg[`ART_CTRL_LOF] <= 1'b1;
      end
      if (wr_ckc) begin
        clock_control_reg <= w_data[1:0];
      end
      if (wr_ien) begin
        extended_interrupt_enable_reg <= w_data[0];
      end
      if (wr_mask) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  // low-byte events count only with the low-byte enable set
  wire [1:0] irq_evt = {lo_wrap & low_byte_interrupt_enable, hi_set};

  // sticky, write-one-to-clear; a new event beats the clear
  always @(posedge mclk) begin
    if (rst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~(wr_stat ? w_data[1:0] : 2'h0)) | irq_evt;
    end
  end

  assign irq = extended_interrupt_enable_reg & |(irq_status & irq_mask);

  // ************************************************************
  // axi read channel
  // ************************************************************
  reg [31:0] rd_mux;
  reg        rd_mapped;

  always @* begin
    rd_mux    = 32'h00000000;
    rd_mapped = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `ART_OFS_CTRL:     rd_mux[7:0] = timer_control_reg;
      `ART_OFS_CNT_LO:   rd_mux[7:0] = count[7:0];
      `ART_OFS_CNT_HI:   rd_mux[7:0] = count[15:8];
      `ART_OFS_RL_LO:    rd_mux[7:0] = reload[7:0];
      `ART_OFS_RL_HI:    rd_mux[7:0] = reload[15:8];
      `ART_OFS_CKCTRL:   rd_mux[1:0] = clock_control_reg;
      `ART_OFS_INT_EN:   rd_mux[0]   = extended_interrupt_enable_reg;
      `ART_OFS_IRQ_STAT: rd_mux[1:0] = irq_status;
      `ART_OFS_IRQ_MASK: rd_mux[1:0] = irq_mask;
      default:           rd_mapped   = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  // one read in flight; data registered on the address handshake
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ART_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_mapped ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // synchronised levels kept for visibility only through edges
  wire unused_levels = rtc_level ^ ext_level ^ low_overflow_flag ^ high_overflow_flag
                       ^ (|w_data[31:8]) ^ (|w_strb[3:1]);

endmodule // art_timer

`default_nettype wire

// *** verification/art_timer_checker.sv ***
// concurrent checks on the register bus and interrupt pin of the timer
`timescale 1ns/1ps
`default_nettype none

module art_timer_checker (
  input wire        mclk,
  input wire        rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ************************************************************
  // handshake steps
  // ************************************************************
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ************************************************************
  // assertions
  // ************************************************************
  write_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0) else $error("error read returns data");
  irq_sticky_a: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("interrupt dropped without software write");
  // reset must idle every response and the interrupt
  reset_idle_a: assert property (@(posedge mclk) disable iff (1'b0)
    rst |=> !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("not idle after reset");
endmodule // art_timer_checker

bind art_timer art_timer_checker art_timer_checker_i (
  .mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);

`default_nettype wire

// *** verification/art_timer_tb_top.sv ***
// self-checking testbench for the auto-reload timer
`timescale 1ns/1ps
`default_nettype none
`include "art_defs.vh"

module art_timer_tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  wire         s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  wire         s_axi_wready;
  wire  [1:0]  s_axi_bresp;
  wire         s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  wire         s_axi_arready;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_rresp;
  wire         s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        rtc_clk_pin = 1'b0;
  logic        ext_osc_pin = 1'b0;
  wire         irq;
  int          fail_count = 0;
  int          checks = 0;
  int          pc = 0;
  logic [31:0] rd_v;
  logic [1:0]  rsp;

  art_timer art_timer_i (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rtc_clk_pin(rtc_clk_pin), .ext_osc_pin(ext_osc_pin), .irq(irq)
  );

  // 10 MHz system clock
  always #50 mclk = ~mclk;

  // oscillator pins run free: rtc rises every 40 cycles, ext every 8
  always @(posedge mclk) begin
    pc <= pc + 1;
    if (pc % 20 == 19) rtc_clk_pin <= ~rtc_clk_pin;
    if (pc % 4 == 3) ext_osc_pin <= ~ext_osc_pin;
  end

  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // unknown compares give x, so test against 1 explicitly
  task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask

  // both halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    // ready raised late: the response must stall, and no edge sees bready set twice
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    // read data held a cycle with rready low before it is taken
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_v, e);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs;
    rdchk(`ART_OFS_CTRL, 32'h00);
    rdchk(`ART_OFS_IRQ_MASK, 32'h03);
    rdchk(`ART_OFS_CKCTRL, 32'h00);
    wr(`ART_OFS_CTRL, 32'h2B);
    rdchk(`ART_OFS_CTRL, 32'h2B);
    wr(`ART_OFS_CTRL, 32'h00);
    wr(8'h40, 32'h5A);
    chk({30'h0, rsp}, 32'h2);
    rd(8'h40);
    chk({30'h0, rsp}, 32'h2);
    chk(rd_v, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_ovf;
    wr(`ART_OFS_CKCTRL, 32'h01);
    wr(`ART_OFS_RL_LO, 32'h34);
    wr(`ART_OFS_RL_HI, 32'h12);
    wr(`ART_OFS_CNT_LO, 32'hF0);
    wr(`ART_OFS_CNT_HI, 32'hFF);
    wr(`ART_OFS_INT_EN, 32'h01);
    wr(`ART_OFS_CTRL, 32'h24);
    cyc(30);
    rdchk(`ART_OFS_CTRL, 32'hE4);
    rdchk(`ART_OFS_CNT_HI, 32'h12);
    rdchk(`ART_OFS_IRQ_STAT, 32'h03);
    chk({31'h0, irq}, 32'h1);
    wr(`ART_OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`ART_OFS_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(`ART_OFS_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rdchk(`ART_OFS_CTRL, 32'hE4);
    wr(`ART_OFS_CTRL, 32'h00);
    rdchk(`ART_OFS_CTRL, 32'h00);
    $display("test overflow done");
  endtask

  task automatic t_split;
    wr(`ART_OFS_CKCTRL, 32'h03);
    wr(`ART_OFS_RL_LO, 32'hA0);
    wr(`ART_OFS_RL_HI, 32'h00);
    wr(`ART_OFS_CNT_LO, 32'hFE);
    wr(`ART_OFS_CNT_HI, 32'h55);
    wr(`ART_OFS_CTRL, 32'h08);
    cyc(6);
    rdchk(`ART_OFS_CTRL, 32'h48);
    rdchk(`ART_OFS_CNT_HI, 32'h55);
    rd(`ART_OFS_CNT_LO);
    chk_rng(rd_v, 32'hA0, 32'hAF);
    chk({31'h0, irq}, 32'h0);
    wr(`ART_OFS_CTRL, 32'h2C);
    cyc(200);
    rdchk(`ART_OFS_CTRL, 32'hEC);
    chk({31'h0, irq}, 32'h1);
    rdchk(`ART_OFS_IRQ_STAT, 32'h03);
    wr(`ART_OFS_CTRL, 32'h00);
    wr(`ART_OFS_IRQ_STAT, 32'h3);
    $display("test split done");
  endtask

  // counts in a window; reserved code must not advance at all
  task automatic t_src;
    int e[4] = '{40, 12, 0, 7};
    logic [7:0] a;
    logic [7:0] d;
    wr(`ART_OFS_CKCTRL, 32'h00);
    wr(`ART_OFS_CNT_HI, 32'h00);
    wr(`ART_OFS_CNT_LO, 32'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`ART_OFS_CTRL, 32'h04 | i);
      rd(`ART_OFS_CNT_LO);
      a = rd_v[7:0];
      cyc(480);
      rd(`ART_OFS_CNT_LO);
      d = rd_v[7:0] - a;
      chk_rng({24'h0, d}, e[i] - (i != 2), e[i] + (i != 2));
    end
    wr(`ART_OFS_CTRL, 32'h00);
    wr(`ART_OFS_CKCTRL, 32'h01);
    rd(`ART_OFS_CNT_LO);
    a = rd_v[7:0];
    cyc(50);
    rd(`ART_OFS_CNT_LO);
    chk({24'h0, rd_v[7:0]}, {24'h0, a});
    $display("test sources done");
  endtask

  // clear the event, wait for the next capture, read both bytes
  task automatic cap_rd(output logic [15:0] v);
    int n;
    wr(`ART_OFS_IRQ_STAT, 32'h3);
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rd(`ART_OFS_RL_HI);
    v[15:8] = rd_v[7:0];
    rd(`ART_OFS_RL_LO);
    v[7:0] = rd_v[7:0];
  endtask

  task automatic t_cap;
    int p[2] = '{40, 64};
    logic [15:0] v0;
    logic [15:0] v1;
    logic [15:0] d;
    wr(`ART_OFS_CKCTRL, 32'h01);
    wr(`ART_OFS_INT_EN, 32'h01);
    for (int i = 0; i < 2; i++) begin
      wr(`ART_OFS_CTRL, 32'h15 + 2 * i);
      cap_rd(v0);
      cap_rd(v1);
      d = v1 - v0;
      chk({16'h0, d}, p[i]);
      rd(`ART_OFS_CTRL);
      chk({31'h0, rd_v[7]}, 32'h1);
    end
    wr(`ART_OFS_CTRL, 32'h00);
    wr(`ART_OFS_IRQ_STAT, 32'h3);
    wr(`ART_OFS_INT_EN, 32'h00);
    $display("test capture done");
  endtask

  // ************************************************************
  // verdict, sequence and watchdog
  // ************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    cyc(6);
    rst <= 1'b0;
    t_regs;
    t_ovf;
    t_split;
    t_src;
    t_cap;
    give_verdict;
  end

  // the whole run needs about 2700 cycles; allow over seven times that
  initial begin
    #(20000 * 100);
    fail_count++;
    give_verdict;
  end
endmodule // art_timer_tb_top

`default_nettype wire
